// >>> hw/bcd_pkg.sv
// constants, register map and types for the charger port detect block
package bcd_pkg;
  localparam int unsigned CLOCK_MHZ = 25;
  localparam int unsigned ADC_WIDTH = 10;
  localparam int unsigned ADC_FULL_MV = 3300;
  localparam int unsigned CDP_HIGH_MV = 600;
  localparam int unsigned CDP_LOW_MV = 250;
  localparam int unsigned DETECT_MV = 250;
  localparam logic [9:0] CDP_HIGH_CODE = 10'(CDP_HIGH_MV * (2 ** ADC_WIDTH) / ADC_FULL_MV);
  localparam logic [9:0] CDP_LOW_CODE = 10'(CDP_LOW_MV * (2 ** ADC_WIDTH) / ADC_FULL_MV);
  localparam logic [9:0] DETECT_CODE = 10'(DETECT_MV * (2 ** ADC_WIDTH) / ADC_FULL_MV);
  localparam int unsigned AUTO_DWELL_US = 1000;
  localparam int unsigned AUTO_DWELL_CYCLES = AUTO_DWELL_US * CLOCK_MHZ;
  localparam int unsigned TIMER_WIDTH = 16;

  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam int unsigned MODE_LSB = 0;
  localparam int unsigned ECHO_BIT = 4;
  localparam int unsigned DETECT_BIT = 5;
  localparam int unsigned LOCKED_BIT = 6;
  localparam int unsigned INHIBIT_BIT = 7;
  localparam int unsigned SCHEME_LSB = 8;

  typedef enum logic [3:0] {
    MODE_OFF = 4'h0,
    MODE_DCD = 4'h1,
    MODE_PRIMARY = 4'h2,
    MODE_SECONDARY = 4'h3,
    MODE_CDP = 4'h4,
    MODE_DCP = 4'h5,
    MODE_DIV3 = 4'h6,
    MODE_LOWV = 4'h7,
    MODE_AUTO = 4'h8
  } bcd_mode_t;

  localparam bcd_mode_t MODE_RESET = MODE_OFF;
endpackage

// >>> hw/bcd_level_detect.sv
// hysteresis comparator on internal converter samples
`timescale 1ns/1ps
`default_nettype none
module bcd_level_detect #(
  parameter int unsigned WIDTH = 10,
  parameter logic [9:0] HIGH_CODE = 10'h100,
  parameter logic [9:0] LOW_CODE = 10'h080
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clear,
  input wire logic sampleValid,
  input wire logic [WIDTH-1:0] sample,
  output logic levelHigh
);
  // samples only steer this flag; the raw value never leaves the block
  always_ff @(posedge clock) begin
    if (!rst_n || clear) begin
      levelHigh <= 1'b0;
    end else if (sampleValid) begin
      if (sample >= WIDTH'(HIGH_CODE)) begin
        levelHigh <= 1'b1;
      end else if (sample < WIDTH'(LOW_CODE)) begin
        levelHigh <= 1'b0;
      end
    end
  end

  cleared_low_a: assert property (@(posedge clock) disable iff (!rst_n) clear |=> !levelHigh) // RL10
    else $error("level flag survived a clear");
endmodule
`default_nettype wire

// >>> hw/bcd_dwell_timer.sv
// reloadable down counter for the automatic scheme dwell
`timescale 1ns/1ps
`default_nettype none
module bcd_dwell_timer #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned CYCLES = 25000
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic restart,
  output logic expired
);
  logic [WIDTH-1:0] count;

  always_ff @(posedge clock) begin
    if (!rst_n || restart) begin
      count <= WIDTH'(CYCLES - 1);
    end else if (count != '0) begin
      count <= count - 1'b1;
    end
  end

  assign expired = (count == '0) && !restart;
endmodule
`default_nettype wire

// >>> hw/bcd_charger_port.sv
// battery charger detection and advertisement sequencing on the data pair
//
// The implementer's own choices: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// RL1: contact detect: D+ current, D- pulldown
// RL2: detection: source one line, sink other, sample
// RL3: charging port echoes D+ level onto D-
// RL4: source and sink on through whole handshake
// RL5: dedicated mode shorts lines via resistor
// RL6: divider mode drives both lines
// RL7: low-voltage mode drives D-, shorts lines
// RL8: automatic mode applies the accepted scheme
// RL9: scheme changes keep bus supply up
// RL10: converter samples stay internal only
// RL11: only one mode drives lines at once
module bcd_charger_port #(
  parameter int unsigned ADC_WIDTH = bcd_pkg::ADC_WIDTH,
  parameter int unsigned AUTO_DWELL_CYCLES = bcd_pkg::AUTO_DWELL_CYCLES
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [7:0] address,
  input wire logic [31:0] writeData,
  input wire logic writeStrobe,
  input wire logic readStrobe,
  output logic [31:0] readData,
  input wire logic [ADC_WIDTH-1:0] adcSample,
  input wire logic adcValid,
  input wire logic deviceAttached,
  input wire logic sinkDrawHigh,
  output logic adcSelectDminus,
  output logic dplusContactCurrent,
  output logic dminusGroundPulldown,
  output logic lineVoltageSource,
  output logic sourceToDplus,
  output logic sourceToDminus,
  output logic lineCurrentSink,
  output logic sinkOnDplus,
  output logic sinkOnDminus,
  output logic lineShortResistor,
  output logic dividerThreeDrive,
  output logic lowVoltageDrive,
  output logic vbusDischargeInhibit
);
  bcd_pkg::bcd_mode_t ctrlMode;
  bcd_pkg::bcd_mode_t activeMode;
  bcd_pkg::bcd_mode_t autoScheme;
  bcd_pkg::bcd_mode_t driveMode;
  bcd_pkg::bcd_mode_t writeMode;
  logic autoLocked;
  logic autoGap;
  logic echoActive;
  logic detectResult;
  logic cdpHigh;
  logic detectHigh;
  logic modeChanging;
  logic dwellExpired;
  logic next_dplusContactCurrent;
  logic next_dminusGroundPulldown;
  logic next_lineVoltageSource;
  logic next_sourceToDplus;
  logic next_sourceToDminus;
  logic next_lineCurrentSink;
  logic next_sinkOnDplus;
  logic next_sinkOnDminus;
  logic next_lineShortResistor;
  logic next_dividerThreeDrive;
  logic next_lowVoltageDrive;
  logic next_adcSelectDminus;
  logic [31:0] next_readData;

  // illegal mode codes fall back to off rather than a half-known drive
  always_comb begin
    case (writeData[3:0])
      4'h1: writeMode = bcd_pkg::MODE_DCD;
      4'h2: writeMode = bcd_pkg::MODE_PRIMARY;
      4'h3: writeMode = bcd_pkg::MODE_SECONDARY;
      4'h4: writeMode = bcd_pkg::MODE_CDP;
      4'h5: writeMode = bcd_pkg::MODE_DCP;
      4'h6: writeMode = bcd_pkg::MODE_DIV3;
      4'h7: writeMode = bcd_pkg::MODE_LOWV;
      4'h8: writeMode = bcd_pkg::MODE_AUTO;
      default: writeMode = bcd_pkg::MODE_OFF;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ctrlMode <= bcd_pkg::MODE_RESET;
    end else if (writeStrobe && address == bcd_pkg::CTRL_OFFSET) begin
      ctrlMode <= writeMode;
    end
  end

  // break before make: one idle cycle between two modes
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      activeMode <= bcd_pkg::MODE_RESET;
    end else if (ctrlMode != activeMode) begin
      activeMode <= (activeMode != bcd_pkg::MODE_OFF) ? bcd_pkg::MODE_OFF : ctrlMode; // RL11
    end
  end

  assign modeChanging = (ctrlMode != activeMode);

  bcd_level_detect #(
    .WIDTH(ADC_WIDTH),
    .HIGH_CODE(bcd_pkg::CDP_HIGH_CODE),
    .LOW_CODE(bcd_pkg::CDP_LOW_CODE)
  ) cdpLevel (
    .clock(clock),
    .rst_n(rst_n),
    .clear(activeMode != bcd_pkg::MODE_CDP),
    .sampleValid(adcValid),
    .sample(adcSample),
    .levelHigh(cdpHigh)
  );

  bcd_level_detect #(
    .WIDTH(ADC_WIDTH),
    .HIGH_CODE(bcd_pkg::DETECT_CODE),
    .LOW_CODE(bcd_pkg::DETECT_CODE)
  ) detectLevel (
    .clock(clock),
    .rst_n(rst_n),
    .clear(modeChanging),
    .sampleValid(adcValid),
    .sample(adcSample),
    .levelHigh(detectHigh)
  );

  // echo D+ onto D- from D+ reaching the high threshold until it drops below the low one
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      echoActive <= 1'b0;
    end else begin
      echoActive <= (activeMode == bcd_pkg::MODE_CDP) && !modeChanging && cdpHigh; // RL3
    end
  end

  // result kept after the phase so software can read it later
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      detectResult <= 1'b0;
    end else if ((activeMode == bcd_pkg::MODE_PRIMARY || activeMode == bcd_pkg::MODE_SECONDARY) && adcValid) begin
      detectResult <= detectHigh; // RL2
    end
  end

  // automatic scheme search; the dwell restarts while locked or idle
  bcd_dwell_timer #(
    .WIDTH(bcd_pkg::TIMER_WIDTH),
    .CYCLES(AUTO_DWELL_CYCLES)
  ) dwellTimer (
    .clock(clock),
    .rst_n(rst_n),
    .restart(activeMode != bcd_pkg::MODE_AUTO || autoGap || autoLocked),
    .expired(dwellExpired)
  );

  always_ff @(posedge clock) begin
    if (!rst_n || activeMode != bcd_pkg::MODE_AUTO) begin
      autoScheme <= bcd_pkg::MODE_DCP;
      autoLocked <= 1'b0;
      autoGap <= 1'b0;
    end else if (autoGap) begin
      autoGap <= 1'b0;
    end else if (autoLocked) begin
      if (!deviceAttached) begin
        autoLocked <= 1'b0;
        autoScheme <= bcd_pkg::MODE_DCP;
        autoGap <= 1'b1;
      end
    end else if (sinkDrawHigh && deviceAttached) begin
      autoLocked <= 1'b1; // RL8
    end else if (dwellExpired) begin
      autoGap <= 1'b1;
      case (autoScheme)
        bcd_pkg::MODE_DCP: autoScheme <= bcd_pkg::MODE_DIV3; // RL8
        bcd_pkg::MODE_DIV3: autoScheme <= bcd_pkg::MODE_LOWV;
        default: autoScheme <= bcd_pkg::MODE_DCP;
      endcase
    end
  end

  // supply is never dropped while the search swaps schemes
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      vbusDischargeInhibit <= 1'b0;
    end else begin
      vbusDischargeInhibit <= (activeMode == bcd_pkg::MODE_AUTO); // RL9
    end
  end

  always_comb begin
    if (activeMode == bcd_pkg::MODE_AUTO) begin
      driveMode = autoGap ? bcd_pkg::MODE_OFF : autoScheme;
    end else if (modeChanging) begin
      driveMode = bcd_pkg::MODE_OFF;
    end else begin
      driveMode = activeMode;
    end
  end

  // one decode from one mode keeps every other switch open
  always_comb begin
    next_dplusContactCurrent = 1'b0;
    next_dminusGroundPulldown = 1'b0;
    next_lineVoltageSource = 1'b0;
    next_sourceToDplus = 1'b0;
    next_sourceToDminus = 1'b0;
    next_lineCurrentSink = 1'b0;
    next_sinkOnDplus = 1'b0;
    next_sinkOnDminus = 1'b0;
    next_lineShortResistor = 1'b0;
    next_dividerThreeDrive = 1'b0;
    next_lowVoltageDrive = 1'b0;
    next_adcSelectDminus = 1'b0;
    case (driveMode) // RL11
      bcd_pkg::MODE_DCD: begin
        next_dplusContactCurrent = 1'b1; // RL1
        next_dminusGroundPulldown = 1'b1; // RL1
      end
      bcd_pkg::MODE_PRIMARY: begin
        next_lineVoltageSource = 1'b1; // RL2
        next_sourceToDplus = 1'b1;
        next_lineCurrentSink = 1'b1;
        next_sinkOnDminus = 1'b1;
        next_adcSelectDminus = 1'b1;
      end
      bcd_pkg::MODE_SECONDARY: begin
        next_lineVoltageSource = 1'b1; // RL2
        next_sourceToDminus = 1'b1;
        next_lineCurrentSink = 1'b1;
        next_sinkOnDplus = 1'b1;
      end
      bcd_pkg::MODE_CDP: begin
        next_lineVoltageSource = 1'b1; // RL4
        next_lineCurrentSink = 1'b1; // RL4
        next_sinkOnDplus = 1'b1;
        next_sourceToDminus = echoActive; // RL3
      end
      bcd_pkg::MODE_DCP: begin
        next_lineShortResistor = 1'b1; // RL5
      end
      bcd_pkg::MODE_DIV3: begin
        next_dividerThreeDrive = 1'b1; // RL6
      end
      bcd_pkg::MODE_LOWV: begin
        next_lowVoltageDrive = 1'b1; // RL7
        next_lineShortResistor = 1'b1; // RL7
      end
      default: begin
        next_lineShortResistor = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      dplusContactCurrent <= 1'b0;
      dminusGroundPulldown <= 1'b0;
      lineVoltageSource <= 1'b0;
      sourceToDplus <= 1'b0;
      sourceToDminus <= 1'b0;
      lineCurrentSink <= 1'b0;
      sinkOnDplus <= 1'b0;
      sinkOnDminus <= 1'b0;
      lineShortResistor <= 1'b0;
      dividerThreeDrive <= 1'b0;
      lowVoltageDrive <= 1'b0;
      adcSelectDminus <= 1'b0;
    end else begin
      dplusContactCurrent <= next_dplusContactCurrent;
      dminusGroundPulldown <= next_dminusGroundPulldown;
      lineVoltageSource <= next_lineVoltageSource;
      sourceToDplus <= next_sourceToDplus;
      sourceToDminus <= next_sourceToDminus;
      lineCurrentSink <= next_lineCurrentSink;
      sinkOnDplus <= next_sinkOnDplus;
      sinkOnDminus <= next_sinkOnDminus;
      lineShortResistor <= next_lineShortResistor;
      dividerThreeDrive <= next_dividerThreeDrive;
      lowVoltageDrive <= next_lowVoltageDrive;
      adcSelectDminus <= next_adcSelectDminus;
    end
  end

  // status shows flags and mode fields; raw converter codes have no read path
  always_comb begin
    next_readData = 32'h0000_0000;
    if (readStrobe) begin
      case (address)
        bcd_pkg::CTRL_OFFSET: begin
          next_readData[bcd_pkg::MODE_LSB +: 4] = ctrlMode;
        end
        bcd_pkg::STATUS_OFFSET: begin
          next_readData[bcd_pkg::MODE_LSB +: 4] = activeMode;
          next_readData[bcd_pkg::ECHO_BIT] = echoActive;
          next_readData[bcd_pkg::DETECT_BIT] = detectResult; // RL10
          next_readData[bcd_pkg::LOCKED_BIT] = autoLocked;
          next_readData[bcd_pkg::INHIBIT_BIT] = vbusDischargeInhibit;
          next_readData[bcd_pkg::SCHEME_LSB +: 4] = autoScheme;
        end
        default: begin
          next_readData = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      readData <= 32'h0000_0000;
    end else begin
      readData <= next_readData;
    end
  end

  contact_phase_a: assert property (@(posedge clock) disable iff (!rst_n) // RL1
    (driveMode == bcd_pkg::MODE_DCD) |=> (dplusContactCurrent && dminusGroundPulldown))
    else $error("contact current or pulldown missing");
  contact_release_a: assert property (@(posedge clock) disable iff (!rst_n) // RL1
    (driveMode != bcd_pkg::MODE_DCD) |=> !dplusContactCurrent && !dminusGroundPulldown)
    else $error("contact drive left on after phase");
  primary_detect_a: assert property (@(posedge clock) disable iff (!rst_n) // RL2
    (driveMode == bcd_pkg::MODE_PRIMARY) |=> (sourceToDplus && sinkOnDminus && adcSelectDminus))
    else $error("primary detection drive wrong");
  cdp_echo_a: assert property (@(posedge clock) disable iff (!rst_n) // RL3
    (activeMode == bcd_pkg::MODE_CDP && !modeChanging && cdpHigh) ##1
    (driveMode == bcd_pkg::MODE_CDP) |=> sourceToDminus)
    else $error("D- echo not applied");
  cdp_hold_a: assert property (@(posedge clock) disable iff (!rst_n) // RL4
    (driveMode == bcd_pkg::MODE_CDP)[*2] |=> (lineVoltageSource && lineCurrentSink && sinkOnDplus))
    else $error("handshake source or sink dropped");
  dcp_short_a: assert property (@(posedge clock) disable iff (!rst_n) // RL5
    (driveMode == bcd_pkg::MODE_DCP) |=> (lineShortResistor && !lowVoltageDrive && !dividerThreeDrive))
    else $error("dedicated short not alone");
  divider_drive_a: assert property (@(posedge clock) disable iff (!rst_n) // RL6
    (driveMode == bcd_pkg::MODE_DIV3) |=> (dividerThreeDrive && !lineShortResistor))
    else $error("divider drive missing");
  lowv_drive_a: assert property (@(posedge clock) disable iff (!rst_n) // RL7
    (driveMode == bcd_pkg::MODE_LOWV) |=> (lowVoltageDrive && lineShortResistor))
    else $error("low voltage scheme incomplete");
  auto_lock_a: assert property (@(posedge clock) disable iff (!rst_n) // RL8
    (activeMode == bcd_pkg::MODE_AUTO && !autoGap && !autoLocked && sinkDrawHigh && deviceAttached)
    |=> autoLocked && $stable(autoScheme))
    else $error("automatic scheme not kept on response");
  auto_supply_a: assert property (@(posedge clock) disable iff (!rst_n) // RL9
    (activeMode == bcd_pkg::MODE_AUTO) ##1 (activeMode == bcd_pkg::MODE_AUTO) |-> vbusDischargeInhibit)
    else $error("supply discharge allowed during search");
  status_clean_a: assert property (@(posedge clock) disable iff (!rst_n) // RL10
    readData[31:12] == 20'h0_0000)
    else $error("unexpected bits on read data");
  single_mode_a: assert property (@(posedge clock) disable iff (!rst_n) // RL11
    $onehot0({dplusContactCurrent, lineVoltageSource, lineShortResistor || lowVoltageDrive, dividerThreeDrive}))
    else $error("two modes drive the lines");
endmodule
`default_nettype wire

// >>> verification/bcd_attached_device.sv
// attached portable device model seen through the converter and the advertisement drives
`timescale 1ns/1ps
`default_nettype none
module bcd_attached_device #(
  parameter int unsigned WIDTH = 10
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic present,
  input wire logic [11:0] dplusMv,
  input wire logic [11:0] dminusMv,
  input wire logic [3:0] acceptScheme,
  input wire logic adcSelectDminus,
  input wire logic sourceToDminus,
  input wire logic lineShortResistor,
  input wire logic dividerThreeDrive,
  input wire logic lowVoltageDrive,
  output logic [WIDTH-1:0] adcSample,
  output logic adcValid,
  output logic deviceAttached,
  output logic sinkDrawHigh
);
  logic [1:0] phase;
  logic [11:0] lineMv;
  logic [WIDTH-1:0] code;
  logic recognised;
  // the echoed level overrides whatever the device puts on D-
  assign lineMv = adcSelectDminus ? (sourceToDminus ? 12'h258 : dminusMv) : dplusMv;
  assign code = WIDTH'((32'(lineMv) * 32'h400) / 32'hCE4);
  assign deviceAttached = present;
  // the device only draws raised current once its own scheme is on the pair
  always_comb begin
    case (acceptScheme)
      4'h5: recognised = lineShortResistor && !lowVoltageDrive;
      4'h6: recognised = dividerThreeDrive;
      4'h7: recognised = lowVoltageDrive && lineShortResistor;
      default: recognised = 1'b0;
    endcase
  end
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      phase <= 2'h0;
      adcValid <= 1'b0;
      adcSample <= '0;
      sinkDrawHigh <= 1'b0;
    end else begin
      phase <= phase + 2'h1;
      adcValid <= (phase == 2'h3);
      // outside the valid pulse the sample bus carries junk, not the last code
      adcSample <= (phase == 2'h3) ? code : ~code;
      sinkDrawHigh <= present && recognised;
    end
  end
endmodule
`default_nettype wire

// >>> verification/tb_bcd_charger_port.sv
// self-checking bench for the charger port detect block
`timescale 1ns/1ps
`default_nettype none
module tb_bcd_charger_port;
  localparam int unsigned DWELL = 20;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] address = 8'h00;
  logic [31:0] writeData = 32'h0;
  logic writeStrobe = 1'b0;
  logic readStrobe = 1'b0;
  logic present = 1'b0;
  logic [11:0] dplusMv = 12'h000;
  logic [11:0] dminusMv = 12'h000;
  logic [3:0] acceptScheme = 4'h0;
  logic [31:0] readData;
  logic [9:0] adcSample;
  logic adcValid, deviceAttached, sinkDrawHigh, adcSelectDminus, dplusContactCurrent, dminusGroundPulldown;
  logic lineVoltageSource, sourceToDplus, sourceToDminus, lineCurrentSink, sinkOnDplus, sinkOnDminus;
  logic lineShortResistor, dividerThreeDrive, lowVoltageDrive, vbusDischargeInhibit;
  wire logic [12:0] lines = {adcSelectDminus, dplusContactCurrent, dminusGroundPulldown, lineVoltageSource,
    sourceToDplus, sourceToDminus, lineCurrentSink, sinkOnDplus, sinkOnDminus, lineShortResistor,
    dividerThreeDrive, lowVoltageDrive, vbusDischargeInhibit};
  int mismatches = 0;
  int checks = 0;
  int cycles = 0;
  logic [31:0] st;

  bcd_charger_port #(.AUTO_DWELL_CYCLES(DWELL)) bcd_charger_port_inst (.clock(clock), .rst_n(rst_n),
    .address(address), .writeData(writeData), .writeStrobe(writeStrobe), .readStrobe(readStrobe),
    .readData(readData), .adcSample(adcSample), .adcValid(adcValid), .deviceAttached(deviceAttached),
    .sinkDrawHigh(sinkDrawHigh), .adcSelectDminus(adcSelectDminus), .dplusContactCurrent(dplusContactCurrent),
    .dminusGroundPulldown(dminusGroundPulldown), .lineVoltageSource(lineVoltageSource),
    .sourceToDplus(sourceToDplus), .sourceToDminus(sourceToDminus), .lineCurrentSink(lineCurrentSink),
    .sinkOnDplus(sinkOnDplus), .sinkOnDminus(sinkOnDminus), .lineShortResistor(lineShortResistor),
    .dividerThreeDrive(dividerThreeDrive), .lowVoltageDrive(lowVoltageDrive),
    .vbusDischargeInhibit(vbusDischargeInhibit));

  bcd_attached_device bcd_attached_device_inst (.clock(clock), .rst_n(rst_n), .present(present),
    .dplusMv(dplusMv), .dminusMv(dminusMv), .acceptScheme(acceptScheme), .adcSelectDminus(adcSelectDminus),
    .sourceToDminus(sourceToDminus), .lineShortResistor(lineShortResistor),
    .dividerThreeDrive(dividerThreeDrive), .lowVoltageDrive(lowVoltageDrive), .adcSample(adcSample),
    .adcValid(adcValid), .deviceAttached(deviceAttached), .sinkDrawHigh(sinkDrawHigh));

  always #20 clock = ~clock;

  task automatic finish_test();
    $display("mismatches %0d checks %0d", mismatches, checks);
    if (mismatches == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // a hang in any wait lands here instead of running forever
  always @(posedge clock) begin
    cycles = cycles + 1;
    if (cycles == 5000) begin
      mismatches = mismatches + 1;
      finish_test();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks = checks + 1;
    if (seen !== exp) begin
      mismatches = mismatches + 1;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wait_cycles(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    address <= a;
    writeData <= d;
    writeStrobe <= 1'b1;
    @(posedge clock);
    writeStrobe <= 1'b0;
  endtask

  // read data stand only in the cycle after the taking edge
  task automatic bus_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    address <= a;
    readStrobe <= 1'b1;
    @(posedge clock);
    readStrobe <= 1'b0;
    #1;
    d = readData;
  endtask

  task automatic read_check(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] mask);
    logic [31:0] v;
    bus_read(a, v);
    check(v & mask, exp & mask);
  endtask

  // several cycles cover the all-off gap between modes
  task automatic mode_check(input logic [3:0] m, input logic [12:0] exp, input logic [12:0] mask);
    bus_write(bcd_pkg::CTRL_OFFSET, {28'h0, m});
    wait_cycles(5);
    check({19'h0, lines & mask}, {19'h0, exp & mask});
  endtask

  initial begin
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    wait_cycles(1);
    check({19'h0, lines}, 32'h0);
    read_check(bcd_pkg::CTRL_OFFSET, 32'h0, 32'hFFFFFFFF);
    // the automatic search parks on the dedicated short while idle
    read_check(bcd_pkg::STATUS_OFFSET, 32'h00000500, 32'hFFFFFFFF);
    mode_check(bcd_pkg::MODE_DCD, 13'h0C00, 13'h1FFF);
    mode_check(bcd_pkg::MODE_PRIMARY, 13'h1350, 13'h1FFF);
    read_check(bcd_pkg::STATUS_OFFSET, 32'h2, 32'h2F);
    dminusMv <= 12'h190;
    wait_cycles(10);
    read_check(bcd_pkg::STATUS_OFFSET, 32'h22, 32'h2F);
    mode_check(bcd_pkg::MODE_SECONDARY, 13'h02E0, 13'h1FFF);
    read_check(bcd_pkg::STATUS_OFFSET, 32'h3, 32'h2F);
    // sink routing in the echo mode is left open, so those two bits are masked
    mode_check(bcd_pkg::MODE_CDP, 13'h0240, 13'h1FCF);
    dplusMv <= 12'h2BC;
    wait_cycles(12);
    check({19'h0, lines & 13'h1FCF}, {19'h0, 13'h02C0});
    read_check(bcd_pkg::STATUS_OFFSET, 32'h14, 32'h1F);
    dplusMv <= 12'h190;
    wait_cycles(12);
    check({19'h0, lines & 13'h1FCF}, {19'h0, 13'h02C0});
    dplusMv <= 12'h000;
    wait_cycles(12);
    check({19'h0, lines & 13'h1FCF}, {19'h0, 13'h0240});
    mode_check(bcd_pkg::MODE_DCP, 13'h0008, 13'h1FFF);
    mode_check(bcd_pkg::MODE_DIV3, 13'h0004, 13'h1FFF);
    mode_check(bcd_pkg::MODE_LOWV, 13'h000A, 13'h1FFF);
    mode_check(4'hF, 13'h0000, 13'h1FFF);
    read_check(bcd_pkg::CTRL_OFFSET, 32'h0, 32'hF);
    dplusMv <= 12'h2BC;
    bus_write(bcd_pkg::STATUS_OFFSET, 32'hFFFFFFFF);
    read_check(bcd_pkg::STATUS_OFFSET, 32'h0, 32'hFFFFF0DF);
    read_check(8'h08, 32'h0, 32'hFFFFFFFF);
    present <= 1'b1;
    for (logic [3:0] s = 4'h5; s <= 4'h7; s++) begin
      acceptScheme <= s;
      bus_write(bcd_pkg::CTRL_OFFSET, {28'h0, bcd_pkg::MODE_AUTO});
      wait_cycles(4);
      for (int i = 0; i < 80; i++) begin
        bus_read(bcd_pkg::STATUS_OFFSET, st);
        check({31'h0, vbusDischargeInhibit}, 32'h1);
        if (st[bcd_pkg::LOCKED_BIT] === 1'b1) begin
          break;
        end
      end
      check(st & 32'h00000F4F, {20'h0, s, 8'h48});
      check({19'h0, lines}, {19'h0, (s == 4'h5) ? 13'h0009 : (s == 4'h6) ? 13'h0005 : 13'h000B});
      // unplugging drops the lock and restarts the search at the short
      present <= 1'b0;
      wait_cycles(4);
      read_check(bcd_pkg::STATUS_OFFSET, 32'h00000588, 32'h00000FCF);
      present <= 1'b1;
      bus_write(bcd_pkg::CTRL_OFFSET, {28'h0, bcd_pkg::MODE_OFF});
      wait_cycles(4);
    end
    finish_test();
  end
endmodule
`default_nettype wire
